//--- sim/tap_data_scan_and_debug_breaks_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, s) begin \
  compares++; \
  if ((s) !== (e)) begin \
    n_fail++; \
    $display("MISMATCH %s exp %h got %h", n, e, s); \
  end \
end
module tap_data_scan_and_debug_breaks_tb
  import tap_pkg::*;
;
  // Arbitrary identification value; bit 0 stays set.
  localparam logic [ID_W-1:0] DEV_ID = 32'h2000_0003;
  logic clk_i = 1'h0;
  logic reset_i = 1'h1;
  logic dev_reset = 1'h1;
  logic jtag_en = 1'h1;
  logic cmd_valid = 1'h0;
  logic cmd_reset = 1'h0;
  logic cmd_ir = 1'h0;
  logic res_ready = 1'h0;
  logic cmd_ready, res_valid, comm_valid, instr_valid, exec, brk;
  logic [LEN_W-1:0] cmd_len = 7'h1;
  logic [SCAN_W-1:0] cmd_data = '0;
  logic [SCAN_W-1:0] res_data, got, d;
  logic wr = 1'h0;
  logic [COMM_W-1:0] wdata = 8'h0;
  logic [COMM_W-1:0] comm;
  logic [INSTR_W-1:0] instr;
  logic pc_valid = 1'h0;
  logic dm_valid = 1'h0;
  logic flow = 1'h0;
  logic step = 1'h0;
  logic [PC_W-1:0] pc = 16'h0;
  logic [PC_W-1:0] dm = 16'h0;
  logic [PC_W-1:0] base, miss;
  logic [31:0] seed = 32'h3d9d;
  int n_fail = 0;
  int compares = 0;
  int hits;
  int n_comm = 0;
  int n_instr = 0;

  tap_link_if lnk ();
  tap_host #(.HALF(6)) u_tap_host (.clk_i(clk_i), .reset_i(reset_i), .link(lnk),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_reset_i(cmd_reset),
    .cmd_ir_i(cmd_ir), .cmd_len_i(cmd_len), .cmd_data_i(cmd_data), .res_valid_o(res_valid),
    .res_ready_i(res_ready), .res_data_o(res_data));
  tap_device #(.ID_CODE(DEV_ID)) u_tap_device (.link(lnk), .reset_i(dev_reset),
    .jtag_en_i(jtag_en), .cpu_result_wr_i(wr), .cpu_result_i(wdata), .comm_o(comm),
    .comm_valid_o(comm_valid), .instr_o(instr), .instr_valid_o(instr_valid), .exec_o(exec),
    .pc_valid_i(pc_valid), .pc_i(pc), .dm_valid_i(dm_valid), .dm_addr_i(dm),
    .flow_change_i(flow), .instr_done_i(step), .break_o(brk));
  tap_link_asserts u_tap_link_asserts (.tck(lnk.tck), .reset_i(dev_reset), .tms(lnk.tms),
    .tdi(lnk.tdi), .tdo_oe(lnk.tdo_oe), .pull_en(lnk.pull_en), .tdo(lnk.tdo));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  // Update strobes are counted, so a missing or doubled pulse shows up.
  always @(negedge lnk.tck) begin
    n_comm += int'(comm_valid === 1'h1);
    n_instr += int'(instr_valid === 1'h1);
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [SCAN_W-1:0] keep(input logic [SCAN_W-1:0] v, input int n);
    return v & ((SCAN_W'(1) << n) - SCAN_W'(1));
  endfunction : keep

  task automatic final_report();
    if (n_fail == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  task automatic send(input logic rst, input logic ir, input int len, input logic [SCAN_W-1:0] v);
    int n;
    n = 0;
    @(negedge clk_i);
    cmd_reset = rst;
    cmd_ir = ir;
    cmd_len = LEN_W'(len);
    cmd_data = v;
    cmd_valid = 1'h1;
    while (cmd_ready !== 1'h1 && n < 5000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 5000) begin
      n_fail++;
    end
    @(negedge clk_i);
    cmd_valid = 1'h0;
  endtask : send

  task automatic recv(output logic [SCAN_W-1:0] r);
    int n;
    n = 0;
    while (res_valid !== 1'h1 && n < 5000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 5000) begin
      n_fail++;
    end
    r = res_data;
    res_ready = 1'h1;
    @(negedge clk_i);
    res_ready = 1'h0;
  endtask : recv

  // A reset command pushes no result of its own, so drain one only if it is there.
  task automatic do_reset();
    send(1'h1, 1'h0, 1, '0);
    repeat (200) @(negedge clk_i);
    if (res_valid === 1'h1) begin
      recv(got);
    end
  endtask : do_reset

  task automatic dr(input int len, input logic [SCAN_W-1:0] v, input logic [SCAN_W-1:0] e);
    send(1'h0, 1'h0, len, v);
    recv(got);
    `CHK("dr scan", keep(e, len), got)
  endtask : dr

  task automatic load_ir(input logic [IR_W-1:0] op);
    send(1'h0, 1'h1, IR_W, SCAN_W'(op));
    recv(got);
    `CHK("ir capture", SCAN_W'(IR_CAPTURE_VAL), got)
  endtask : load_ir

  task automatic set_cfg(input logic [1:0] mode, input logic [1:0] fs, input logic [3:0] en);
    logic [SCAN_W-1:0] c;
    c = '0;
    c[BP_MODE_POS +: 2] = mode;
    c[BP_FLOW_POS +: 2] = fs;
    c[BP_EN_POS +: 4] = en;
    for (int k = 0; k < BP_COUNT; k++) begin
      c[BP_ADDR_POS + 16 * k +: 16] = base | (16'h0100 << k);
    end
    send(1'h0, 1'h0, SCAN_W, c);
    recv(got);
  endtask : set_cfg

  task automatic probe(input logic [PC_W-1:0] p, input logic [PC_W-1:0] a,
      input logic [1:0] fs, input logic e);
    @(negedge lnk.tck);
    pc = p;
    dm = a;
    pc_valid = 1'h1;
    dm_valid = 1'h1;
    flow = fs[0];
    step = fs[1];
    @(negedge lnk.tck);
    pc_valid = 1'h0;
    dm_valid = 1'h0;
    flow = 1'h0;
    step = 1'h0;
    `CHK("break", e, brk)
    @(negedge lnk.tck);
  endtask : probe

  initial begin
    repeat (12) @(negedge clk_i);
    reset_i = 1'h0;
    repeat (80) @(negedge clk_i);
    dev_reset = 1'h0;
    do_reset();
    dr(ID_W, SCAN_W'(rnd()), SCAN_W'(DEV_ID));
    load_ir(OP_BYPASS);
    d = SCAN_W'({rnd(), rnd(), rnd()});
    dr(8, d, {d[SCAN_W-2:0], 1'h0});
    dr(1, d, '0);
    // The reader stalls: two results fill the buffer and the third holds the host.
    send(1'h0, 1'h0, 5, d);
    send(1'h0, 1'h0, SCAN_W, ~d);
    send(1'h0, 1'h0, 3, d);
    hits = 0;
    repeat (300) begin
      @(negedge clk_i);
      hits += int'(cmd_ready === 1'h1);
    end
    `CHK("ready while full", 0, hits)
    recv(got);
    `CHK("stall first", keep({d[SCAN_W-2:0], 1'h0}, 5), got)
    recv(got);
    `CHK("stall second", {~d[SCAN_W-2:0], 1'h0}, got)
    recv(got);
    `CHK("stall third", keep({d[SCAN_W-2:0], 1'h0}, 3), got)
    load_ir(OP_COMM);
    @(negedge lnk.tck);
    wdata = COMM_W'(rnd());
    wr = 1'h1;
    @(negedge lnk.tck);
    wr = 1'h0;
    dr(COMM_W + 1, d, {1'h1, wdata});
    `CHK("comm out", d[COMM_W-1:0], comm)
    dr(COMM_W + 1, ~d, {1'h0, wdata});
    `CHK("comm out again", ~d[COMM_W-1:0], comm)
    load_ir(OP_INJECT);
    `CHK("comm strobes", 2, n_comm)
    dr(INSTR_W, d, '0);
    `CHK("instr out", d[INSTR_W-1:0], instr)
    `CHK("exec in idle", 1'h1, exec)
    dr(INSTR_W, ~d, d);
    load_ir(OP_BYPASS);
    `CHK("exec after change", 1'h0, exec)
    `CHK("instr strobes", 2, n_instr)
    base = (PC_W'(rnd()) & 16'he0ff) | 16'h0001;
    miss = base ^ 16'h0001;
    load_ir(OP_BREAK);
    for (int m = 0; m < 4; m++) begin
      set_cfg(m[1:0], 2'h0, 4'hf);
      probe(base | 16'h0200, miss, 2'h0, 1'h1);
      probe(base | 16'h0800, miss, 2'h0, m == 1);
      probe(miss, base | 16'h0800, 2'h0, m == 0 || m == 2);
      probe(base, miss, 2'h0, m == 3);
    end
    set_cfg(MODE_PM2_DM2, 2'h3, 4'h0);
    probe(miss, miss, 2'h1, 1'h1);
    probe(miss, miss, 2'h2, 1'h1);
    probe(base | 16'h0100, miss, 2'h0, 1'h0);
    do_reset();
    dr(ID_W, d, SCAN_W'(DEV_ID));
    @(negedge lnk.tck);
    jtag_en = 1'h0;
    repeat (3) @(negedge lnk.tck);
    `CHK("pull off", 1'h0, lnk.pull_en)
    `CHK("tdo released", 1'h1, lnk.tdo)
    jtag_en = 1'h1;
    repeat (3) @(negedge lnk.tck);
    `CHK("pull on", 1'h1, lnk.pull_en)
    do_reset();
    dr(ID_W, ~d, SCAN_W'(DEV_ID));
    `CHK("comm strobes end", 2, n_comm)
    final_report();
  end

  initial begin
    #300000;
    n_fail++;
    final_report();
  end
endmodule : tap_data_scan_and_debug_breaks_tb

//--- sim/tap_link_asserts.sv
`timescale 1ns/1ns
module tap_link_asserts
  import tap_pkg::*;
(
  input wire logic tck,
  input wire logic reset_i,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo_oe,
  input wire logic pull_en,
  input wire logic tdo
);
  // The checker follows the wire by itself, so a device in the wrong state shows at tdo.
  tap_state_type st_reg;
  logic [IR_W-1:0] ir_sh_reg;
  logic [IR_W-1:0] ir_reg;

  always_ff @(posedge tck) begin
    if (st_reg == IR_SHIFT) begin
      ir_sh_reg <= {tdi, ir_sh_reg[IR_W-1:1]};
    end
    if (reset_i || !pull_en || st_reg == TAP_RESET) begin
      ir_reg <= OP_IDCODE;
    end else if (st_reg == IR_UPDATE) begin
      ir_reg <= ir_sh_reg;
    end
    if (reset_i || !pull_en) begin
      st_reg <= TAP_RESET;
    end else begin
      case (st_reg)
        TAP_RESET: st_reg <= tms ? TAP_RESET : TAP_IDLE;
        TAP_IDLE: st_reg <= tms ? DR_SELECT : TAP_IDLE;
        DR_SELECT: st_reg <= tms ? IR_SELECT : DR_CAPTURE;
        DR_CAPTURE: st_reg <= tms ? DR_EXIT1 : DR_SHIFT;
        DR_SHIFT: st_reg <= tms ? DR_EXIT1 : DR_SHIFT;
        DR_EXIT1: st_reg <= tms ? DR_UPDATE : DR_PAUSE;
        DR_PAUSE: st_reg <= tms ? DR_EXIT2 : DR_PAUSE;
        DR_EXIT2: st_reg <= tms ? DR_UPDATE : DR_SHIFT;
        DR_UPDATE: st_reg <= tms ? DR_SELECT : TAP_IDLE;
        IR_SELECT: st_reg <= tms ? TAP_RESET : IR_CAPTURE;
        IR_CAPTURE: st_reg <= tms ? IR_EXIT1 : IR_SHIFT;
        IR_SHIFT: st_reg <= tms ? IR_EXIT1 : IR_SHIFT;
        IR_EXIT1: st_reg <= tms ? IR_UPDATE : IR_PAUSE;
        IR_PAUSE: st_reg <= tms ? IR_EXIT2 : IR_PAUSE;
        IR_EXIT2: st_reg <= tms ? IR_UPDATE : IR_SHIFT;
        IR_UPDATE: st_reg <= tms ? DR_SELECT : TAP_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge tck); endclocking
  default disable iff (reset_i);

  sequence dr_enter;
    st_reg == DR_CAPTURE && !tms;
  endsequence
  sequence ir_enter;
    st_reg == IR_CAPTURE && !tms;
  endsequence
  sequence ir_rest_low;
    (st_reg != IR_SHIFT || !tdo) [*3];
  endsequence

  a_shift_only_drive: assert property (tdo_oe == (st_reg inside {DR_SHIFT, IR_SHIFT}))
    else $error("tdo driven outside a shift state");
  a_five_ones_reset: assert property (tms [*5] |=> !tdo_oe ##1 !tdo_oe)
    else $error("five high tms periods did not quiet the port");
  a_capture_drive: assert property (dr_enter or ir_enter |=> tdo_oe)
    else $error("tdo not driven after capture");
  a_exit_release: assert property ((st_reg inside {DR_SHIFT, IR_SHIFT}) && tms |=> !tdo_oe ##1 !tdo_oe)
    else $error("tdo driven in an exit or pause state");
  a_ir_capture_value: assert property (ir_enter |=> tdo ##1 ir_rest_low)
    else $error("instruction capture value wrong on tdo");
  a_bypass_zero: assert property ((dr_enter ##0 (ir_reg == OP_BYPASS)) |=> !tdo)
    else $error("bypass capture not zero");
  a_idcode_first: assert property ((dr_enter ##0 (ir_reg == OP_IDCODE)) |=> tdo)
    else $error("identification bit 0 not first on tdo");
  a_pull_when_drive: assert property (tdo_oe |-> pull_en)
    else $error("tdo driven while pull-ups are off");
endmodule : tap_link_asserts

//--- verilog/pair_buffer.sv
`timescale 1ns/1ns
module pair_buffer
  import tap_pkg::*;
#(
  parameter int W = SCAN_W
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  typedef struct packed {
    logic head_valid;
    logic [W-1:0] head;
    logic tail_valid;
    logic [W-1:0] tail;
    logic ready;
  } buf_state_type;

  buf_state_type r_reg;
  buf_state_type r_next;

  // Readiness is taken from the registered tail, so a word is refused only when both slots hold.
  always_comb begin
    r_next = r_reg;
    if (r_reg.head_valid && out_ready_i) begin
      r_next.head_valid = r_reg.tail_valid;
      r_next.head = r_reg.tail;
      r_next.tail_valid = 1'b0;
    end
    if (in_valid_i && r_reg.ready) begin
      if (!r_next.head_valid) begin
        r_next.head_valid = 1'b1;
        r_next.head = in_data_i;
      end else begin
        r_next.tail_valid = 1'b1;
        r_next.tail = in_data_i;
      end
    end
    r_next.ready = !r_next.tail_valid;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r_reg <= '0;
      r_reg.ready <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign in_ready_o = r_reg.ready;
  assign out_valid_o = r_reg.head_valid;
  assign out_data_o = r_reg.head;

endmodule : pair_buffer

//--- verilog/tap_device.sv
// Operation
// [R1] Controller enters Shift-DR from idle with 1,0,0.
// [R2] Shift-DR takes one bit per edge, last exits.
// [R3] Captured parallel value shifts out during Shift-DR.
// [R4] Return with 1,1,0; outputs latch in Update-DR.
// [R5] Exit and pause states do nothing to registers.
// [R6] Idle may perform functions; idle visit optional.
// [R7] Five TMS-high periods always reach Test-Logic-Reset.
// [R8] Provide CPU chain, break unit, communication path.
// [R9] Injected instructions; CPU writes result to mailbox.
// [R10] Flow, single-step, two program, two combined breaks.
// [R11] Four resources configurable as four program breaks.
// [R12] Sixteen states, TMS at rising edge, reset start.
// [R13] Every shift register moves least significant bit first.
// [R14] Four-bit instructions; capture shifts out value one.
// [R15] No test reset pin; pull-ups while enabled.
// [R16] Drive TDO only when shifting, change on falling.
`timescale 1ns/1ns
module tap_device
  import tap_pkg::*;
#(
  // Arbitrary identification value; only bit 0 carries meaning.
  parameter logic [ID_W-1:0] ID_CODE = 32'h1000_0001
) (
  tap_link_if.device link,
  input wire logic reset_i,
  input wire logic jtag_en_i,
  input wire logic cpu_result_wr_i,
  input wire logic [COMM_W-1:0] cpu_result_i,
  output logic [COMM_W-1:0] comm_o,
  output logic comm_valid_o,
  output logic [INSTR_W-1:0] instr_o,
  output logic instr_valid_o,
  output logic exec_o,
  input wire logic pc_valid_i,
  input wire logic [PC_W-1:0] pc_i,
  input wire logic dm_valid_i,
  input wire logic [PC_W-1:0] dm_addr_i,
  input wire logic flow_change_i,
  input wire logic instr_done_i,
  output logic break_o
);

  typedef struct packed {
    tap_state_type st;
    logic [IR_W-1:0] ir_sr;
    logic [IR_W-1:0] ir;
    logic [SCAN_W-1:0] dr_sr;
    logic [COMM_W-1:0] mailbox;
    logic mailbox_full;
    logic [COMM_W-1:0] comm;
    logic comm_valid;
    logic [INSTR_W-1:0] instr;
    logic instr_valid;
    logic exec;
    logic [SCAN_W-1:0] bp_cfg;
    logic brk;
    logic pull;
  } dev_state_type;

  dev_state_type r_reg;
  dev_state_type r_next;
  logic tdo_reg;
  logic tdo_oe_reg;

  function automatic logic [LEN_W-1:0] dr_len(input logic [IR_W-1:0] op);
    unique case (op)
      OP_IDCODE: return 7'(ID_W);
      OP_COMM: return 7'(COMM_W + 1);
      OP_INJECT: return 7'(INSTR_W);
      OP_BREAK: return 7'(SCAN_W);
      default: return 7'h1;
    endcase
  endfunction : dr_len

  function automatic logic [PC_W-1:0] bp_addr(input logic [SCAN_W-1:0] cfg, input int k);
    return cfg[BP_ADDR_POS + k * PC_W +: PC_W];
  endfunction : bp_addr

  always_comb begin
    logic [LEN_W-1:0] n;
    logic [1:0] mode;
    logic [BP_COUNT-1:0] en;
    logic [BP_COUNT-1:0] pm_hit;
    logic [BP_COUNT-1:0] dm_hit;
    logic range_hit;
    logic hit;
    pm_hit = '0;
    dm_hit = '0;
    range_hit = 1'h0;
    hit = 1'h0;
    n = dr_len(r_reg.ir);
    mode = r_reg.bp_cfg[BP_MODE_POS +: 2];
    en = r_reg.bp_cfg[BP_EN_POS +: BP_COUNT];
    r_next = r_reg;
    r_next.comm_valid = 1'b0;
    r_next.instr_valid = 1'b0;
    r_next.pull = jtag_en_i; // see [R15]
    r_next.st = tap_next(r_reg.st, link.tms); // see [R7] see [R12]
    unique case (r_reg.st)
      TAP_RESET: begin
        r_next.ir = OP_IDCODE;
      end
      IR_CAPTURE: begin
        r_next.ir_sr = IR_CAPTURE_VAL; // see [R14]
      end
      IR_SHIFT: begin
        r_next.ir_sr = {link.tdi, r_reg.ir_sr[IR_W-1:1]}; // see [R13] see [R14]
      end
      IR_UPDATE: begin
        r_next.ir = r_reg.ir_sr;
      end
      DR_CAPTURE: begin
        unique case (r_reg.ir)
          OP_IDCODE: r_next.dr_sr = SCAN_W'(ID_CODE); // see [R3]
          OP_COMM: begin
            r_next.dr_sr = SCAN_W'({r_reg.mailbox_full, r_reg.mailbox}); // see [R3] see [R9]
            r_next.mailbox_full = 1'b0;
          end
          OP_INJECT: r_next.dr_sr = SCAN_W'(r_reg.instr);
          OP_BREAK: r_next.dr_sr = r_reg.bp_cfg;
          default: r_next.dr_sr = '0;
        endcase
      end
      DR_SHIFT: begin
        r_next.dr_sr = r_reg.dr_sr >> 1; // see [R2] see [R13]
        r_next.dr_sr[n - 7'h1] = link.tdi;
      end
      DR_UPDATE: begin
        unique case (r_reg.ir)
          OP_COMM: begin
            r_next.comm = r_reg.dr_sr[COMM_W-1:0]; // see [R4]
            r_next.comm_valid = 1'b1;
          end
          OP_INJECT: begin
            r_next.instr = r_reg.dr_sr[INSTR_W-1:0]; // see [R4] see [R8] see [R9]
            r_next.instr_valid = 1'b1;
          end
          OP_BREAK: r_next.bp_cfg = r_reg.dr_sr; // see [R4] see [R8]
          default: begin
          end
        endcase
      end
      // Exit and pause states only steer the state machine.
      default: begin // see [R5]
      end
    endcase
    // A CPU write in the same edge as a capture keeps the mailbox marked full.
    if (cpu_result_wr_i) begin
      r_next.mailbox = cpu_result_i; // see [R9]
      r_next.mailbox_full = 1'b1;
    end
    if (!jtag_en_i) begin
      r_next.st = TAP_RESET; // see [R15]
      r_next.ir = OP_IDCODE;
    end
    // Injected instructions run while the port rests in idle, so idle is not neutral here.
    r_next.exec = (r_next.st == TAP_IDLE) && (r_next.ir == OP_INJECT); // see [R6]

    for (int k = 0; k < BP_COUNT; k++) begin
      pm_hit[k] = en[k] && pc_valid_i && (pc_i == bp_addr(r_reg.bp_cfg, k)); // see [R10]
      dm_hit[k] = en[k] && dm_valid_i && (dm_addr_i == bp_addr(r_reg.bp_cfg, k));
    end
    // The range form uses resource 3 as a mask: a one bit takes part in the compare.
    range_hit = en[2] && pc_valid_i
      && (((pc_i ^ bp_addr(r_reg.bp_cfg, 2)) & bp_addr(r_reg.bp_cfg, 3)) == '0);
    unique case (mode)
      MODE_PM4: hit = |pm_hit; // see [R11]
      MODE_PM3_DM1: hit = (|pm_hit[2:0]) || dm_hit[3];
      MODE_PM2_RANGE: hit = (|pm_hit[1:0]) || range_hit;
      default: hit = (|pm_hit[1:0]) || (|dm_hit[3:2]); // see [R10]
    endcase
    r_next.brk = hit
      || (r_reg.bp_cfg[BP_FLOW_POS] && flow_change_i) // see [R10]
      || (r_reg.bp_cfg[BP_STEP_POS] && instr_done_i); // see [R10]
  end

  always_ff @(posedge link.tck) begin
    if (reset_i) begin
      r_reg <= '0;
      r_reg.st <= TAP_RESET; // see [R12]
      r_reg.ir <= OP_IDCODE;
    end else begin
      r_reg <= r_next;
    end
  end

  // Launching on the falling edge gives the controller half a period of setup.
  always_ff @(negedge link.tck) begin
    if (reset_i) begin
      tdo_reg <= 1'b1;
      tdo_oe_reg <= 1'b0;
    end else begin
      tdo_reg <= (r_reg.st == IR_SHIFT) ? r_reg.ir_sr[0] : r_reg.dr_sr[0]; // see [R16] see [R3]
      tdo_oe_reg <= (r_reg.st == IR_SHIFT) || (r_reg.st == DR_SHIFT); // see [R16]
    end
  end

  assign link.tdo_out = tdo_reg;
  assign link.tdo_oe = tdo_oe_reg;
  assign link.pull_en = r_reg.pull;
  assign comm_o = r_reg.comm;
  assign comm_valid_o = r_reg.comm_valid;
  assign instr_o = r_reg.instr;
  assign instr_valid_o = r_reg.instr_valid;
  assign exec_o = r_reg.exec;
  assign break_o = r_reg.brk;

endmodule : tap_device

//--- verilog/tap_host.sv
`timescale 1ns/1ns
module tap_host
  import tap_pkg::*;
#(
  parameter int HALF = TCK_HALF_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  tap_link_if.host link,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_reset_i,
  input wire logic cmd_ir_i,
  input wire logic [LEN_W-1:0] cmd_len_i,
  input wire logic [SCAN_W-1:0] cmd_data_i,
  output logic res_valid_o,
  input wire logic res_ready_i,
  output logic [SCAN_W-1:0] res_data_o
);

  typedef enum logic [2:0] {H_RESET, H_IDLE, H_PRE, H_SHIFT, H_POST, H_PUSH} host_phase_type;

  typedef struct packed {
    host_phase_type ph;
    logic tck;
    logic [7:0] cnt;
    logic tms;
    logic tdi;
    logic oe;
    logic [LEN_W-1:0] idx;
    logic is_ir;
    logic [LEN_W-1:0] len;
    logic [SCAN_W-1:0] data;
    logic [SCAN_W-1:0] res;
    logic [2:0] sync;
    logic tdo_seen;
    logic push;
    logic ready;
  } host_state_type;

  host_state_type r_reg;
  host_state_type r_next;
  logic buf_ready;
  logic [3:0] pre_tms;
  logic [LEN_W-1:0] pre_len;

  assign pre_tms = r_reg.is_ir ? IR_PRE_TMS : DR_PRE_TMS;
  assign pre_len = r_reg.is_ir ? IR_PRE_LEN : DR_PRE_LEN;

  // The device samples on the rising link edge; this end changes its pins on the falling one.
  always_comb begin
    r_next = r_reg;
    r_next.sync = {r_reg.sync[1:0], link.tdo};
    if (r_reg.sync[1] == r_reg.sync[2]) begin
      r_next.tdo_seen = r_reg.sync[2];
    end
    if (r_reg.push && buf_ready) begin
      r_next.push = 1'b0;
      r_next.ph = H_IDLE;
    end
    if (r_reg.cnt == 8'(HALF - 1)) begin
      r_next.cnt = 8'h00;
      r_next.tck = !r_reg.tck;
      if (!r_reg.tck) begin
        unique case (r_reg.ph)
          H_RESET: begin
            if (r_reg.idx == RESET_ONES) begin
              r_next.ph = H_IDLE;
            end else begin
              r_next.idx = r_reg.idx + 7'h1;
            end
          end
          H_PRE: begin
            if (r_reg.idx == pre_len - 7'h1) begin
              r_next.ph = H_SHIFT;
              r_next.idx = 7'h0;
            end else begin
              r_next.idx = r_reg.idx + 7'h1;
            end
          end
          H_SHIFT: begin
            r_next.res[r_reg.idx] = r_reg.tdo_seen; // see [R3] see [R13] see [R14]
            if (r_reg.idx == r_reg.len - 7'h1) begin
              r_next.ph = H_POST;
              r_next.idx = 7'h0;
            end else begin
              r_next.idx = r_reg.idx + 7'h1;
            end
          end
          H_POST: begin
            if (r_reg.idx == 7'h1) begin
              r_next.ph = H_PUSH;
              r_next.push = 1'b1;
            end else begin
              r_next.idx = r_reg.idx + 7'h1;
            end
          end
          default: begin
          end
        endcase
      end else begin
        unique case (r_reg.ph)
          H_IDLE: begin
            r_next.tms = 1'b0;
            if (cmd_valid_i && r_reg.ready) begin
              r_next.idx = 7'h0;
              if (cmd_reset_i) begin
                r_next.ph = H_RESET;
                r_next.tms = 1'b1;
              end else begin
                r_next.ph = H_PRE;
                r_next.is_ir = cmd_ir_i;
                r_next.data = cmd_data_i;
                r_next.res = '0;
                r_next.len = (cmd_len_i == 7'h0) ? 7'h1 : cmd_len_i;
                if (cmd_len_i > 7'(SCAN_W)) begin
                  r_next.len = 7'(SCAN_W);
                end
                r_next.tms = cmd_ir_i ? IR_PRE_TMS[0] : DR_PRE_TMS[0]; // see [R1] see [R14]
              end
            end
          end
          H_RESET: r_next.tms = (r_reg.idx < RESET_ONES); // see [R7] see [R12]
          H_PRE: r_next.tms = pre_tms[r_reg.idx[1:0]]; // see [R1] see [R14]
          H_SHIFT: begin
            r_next.tms = (r_reg.idx == r_reg.len - 7'h1); // see [R2]
            r_next.tdi = r_reg.data[r_reg.idx]; // see [R13]
          end
          H_POST: r_next.tms = (r_reg.idx == 7'h0); // see [R4]
          H_PUSH: r_next.tms = 1'b0;
        endcase
      end
    end else begin
      r_next.cnt = r_reg.cnt + 8'h01;
    end
    r_next.ready = (r_next.ph == H_IDLE) && (r_next.cnt == 8'(HALF - 1)) && r_next.tck;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r_reg <= '0;
      r_reg.ph <= H_RESET;
      r_reg.tms <= 1'b1;
      r_reg.oe <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  pair_buffer #(
    .W(SCAN_W)
  ) result_buf (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .in_valid_i(r_reg.push),
    .in_ready_o(buf_ready),
    .in_data_i(r_reg.res),
    .out_valid_o(res_valid_o),
    .out_ready_i(res_ready_i),
    .out_data_o(res_data_o)
  );

  assign link.tck = r_reg.tck;
  assign link.tms_out = r_reg.tms;
  assign link.tms_oe = r_reg.oe;
  assign link.tdi_out = r_reg.tdi;
  assign link.tdi_oe = r_reg.oe;
  assign cmd_ready_o = r_reg.ready;

endmodule : tap_host

//--- verilog/tap_link_if.sv
`timescale 1ns/1ns
interface tap_link_if;
  logic tck;
  logic tms_out;
  logic tms_oe;
  logic tdi_out;
  logic tdi_oe;
  logic tdo_out;
  logic tdo_oe;
  logic pull_en;
  logic tms;
  logic tdi;
  logic tdo;

  // Undriven tms and tdi read high only while the device enables its pull-ups; an undriven tdo always reads high.
  assign tms = tms_oe ? tms_out : pull_en;
  assign tdi = tdi_oe ? tdi_out : pull_en;
  assign tdo = tdo_oe ? tdo_out : 1'b1;

  modport device (
    input tck,
    input tms,
    input tdi,
    output tdo_out,
    output tdo_oe,
    output pull_en
  );

  modport host (
    output tck,
    output tms_out,
    output tms_oe,
    output tdi_out,
    output tdi_oe,
    input tdo
  );
endinterface : tap_link_if

//--- verilog/tap_pkg.sv
package tap_pkg;

  localparam int IR_W = 4;
  localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 4'h1;

  // Instruction codes of the test port.
  localparam logic [IR_W-1:0] OP_IDCODE = 4'h1;
  localparam logic [IR_W-1:0] OP_COMM = 4'h2;
  localparam logic [IR_W-1:0] OP_INJECT = 4'h3;
  localparam logic [IR_W-1:0] OP_BREAK = 4'h4;
  localparam logic [IR_W-1:0] OP_BYPASS = 4'hf;

  localparam int SCAN_W = 72;
  localparam int ID_W = 32;
  localparam int COMM_W = 8;
  localparam int INSTR_W = 16;
  localparam int PC_W = 16;
  localparam int LEN_W = 7;

  // Break point configuration word layout.
  localparam int BP_MODE_POS = 0;
  localparam int BP_FLOW_POS = 2;
  localparam int BP_STEP_POS = 3;
  localparam int BP_EN_POS = 4;
  localparam int BP_ADDR_POS = 8;
  localparam int BP_COUNT = 4;

  localparam logic [1:0] MODE_PM2_DM2 = 2'h0;
  localparam logic [1:0] MODE_PM4 = 2'h1;
  localparam logic [1:0] MODE_PM3_DM1 = 2'h2;
  localparam logic [1:0] MODE_PM2_RANGE = 2'h3;

  // Mode-select sequences, first bit in bit 0.
  localparam logic [3:0] IR_PRE_TMS = 4'h3;
  localparam logic [LEN_W-1:0] IR_PRE_LEN = 7'h4;
  localparam logic [3:0] DR_PRE_TMS = 4'h1;
  localparam logic [LEN_W-1:0] DR_PRE_LEN = 7'h3;
  localparam logic [LEN_W-1:0] RESET_ONES = 7'h5;

  // Link clock made by the controller.
  localparam int CLK_NS = 4;
  localparam int TCK_HALF_NS = 32;
  localparam int TCK_HALF_CYC = (TCK_HALF_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, DR_SELECT, DR_CAPTURE, DR_SHIFT, DR_EXIT1, DR_PAUSE, DR_EXIT2,
    DR_UPDATE, IR_SELECT, IR_CAPTURE, IR_SHIFT, IR_EXIT1, IR_PAUSE, IR_EXIT2, IR_UPDATE
  } tap_state_type;

  function automatic tap_state_type tap_next(input tap_state_type s, input logic tms);
    unique case (s)
      TAP_RESET: return tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: return tms ? DR_SELECT : TAP_IDLE;
      DR_SELECT: return tms ? IR_SELECT : DR_CAPTURE;
      DR_CAPTURE: return tms ? DR_EXIT1 : DR_SHIFT;
      DR_SHIFT: return tms ? DR_EXIT1 : DR_SHIFT;
      DR_EXIT1: return tms ? DR_UPDATE : DR_PAUSE;
      DR_PAUSE: return tms ? DR_EXIT2 : DR_PAUSE;
      DR_EXIT2: return tms ? DR_UPDATE : DR_SHIFT;
      DR_UPDATE: return tms ? DR_SELECT : TAP_IDLE;
      IR_SELECT: return tms ? TAP_RESET : IR_CAPTURE;
      IR_CAPTURE: return tms ? IR_EXIT1 : IR_SHIFT;
      IR_SHIFT: return tms ? IR_EXIT1 : IR_SHIFT;
      IR_EXIT1: return tms ? IR_UPDATE : IR_PAUSE;
      IR_PAUSE: return tms ? IR_EXIT2 : IR_PAUSE;
      IR_EXIT2: return tms ? IR_UPDATE : IR_SHIFT;
      IR_UPDATE: return tms ? DR_SELECT : TAP_IDLE;
    endcase
  endfunction : tap_next

endpackage : tap_pkg
